// file: logic/two_wire_bus_engine_slave_core.sv
// Two-wire bus slave engine with its control and status bits as plain ports.
// Assumes SDA and SCL are open-drain wires with pull-ups outside, and that
// LINK_CLK runs free and fast enough to oversample a fast-mode bus.
`timescale 1ns/10ps
// How it works
// [RULE1] Power-up reset and soft reset both reset; power-up leaves soft reset set.
// [RULE2] Two-wire operation needs serial mode select equal to 11.
// [RULE3] Unit stays idle while soft reset is set; runs once software clears it.
// [RULE4] Soft reset stops bus traffic and releases SDA and SCL.
// [RULE5] Soft reset clears status bits 6-0; other bits keep their values.
// [RULE6] Soft reset clears transmit and receive interrupt enables and flags.
// [RULE7] Software changes configuration only while soft reset is set.
// [RULE8] Bytes move most significant bit first, one SCL pulse per bit.
// [RULE9] First byte after START is 7-bit address plus direction bit.
// [RULE10] Receiver drives acknowledge during the ninth SCL clock.
// [RULE11] START is SDA falling with SCL high; STOP is SDA rising.
// [RULE12] Bus busy sets on START and clears on STOP.
// [RULE13] Transmitter changes SDA only while SCL is low.
// [RULE14] Ten-bit address: 11110 plus two high bits, then eight low bits.
// [RULE15] Repeated START resends the address with a new direction.
// [RULE16] Slave needs mode 11, synchronous select set, master select clear.
// [RULE17] Slave starts as receiver; direction then follows received direction bit.
// [RULE18] Slave matches its own address; ten-bit select chooses the format.
// [RULE19] General call answered only when general call respond is set.
// [RULE20] Start match flag sets only when the received address matches.
// [RULE21] Rates up to 100 kbps standard and 400 kbps fast are supported.
// [RULE22] A START seen as slave receiver raises a wake request.
// [RULE23] Match with direction set enters transmitter mode and sets direction.
// [RULE24] Match with direction clear enters receiver mode and clears direction.
// [RULE25] SDA and SCL are only pulled low or released, never driven high.
module two_wire_bus_engine_slave_core
	import two_wire_pkg::*;
(
	// Clocks and reset.
	input  wire logic       SYS_CLK,
	input  wire logic       RESETN,
	input  wire logic       LINK_CLK,
	// Configuration.
	input  wire logic [1:0] SERIAL_MODE_SELECT,
	input  wire logic       SYNCHRONOUS_MODE_SELECT,
	input  wire logic       MASTER_SELECT,
	input  wire logic [9:0] OWN_ADDRESS_REG,
	input  wire logic       OWN_ADDRESS_TEN_BIT,
	input  wire logic       GENERAL_CALL_RESPOND,
	// Software strobes.
	input  wire logic       SOFT_RESET_SET,
	input  wire logic       SOFT_RESET_CLEAR,
	input  wire logic       DIRECTION_WRITE,
	input  wire logic       DIRECTION_VALUE,
	input  wire logic       IRQ_ENABLE_WRITE,
	input  wire logic [1:0] IRQ_ENABLE_VALUE,
	input  wire logic       START_MATCH_CLEAR,
	input  wire logic       TX_LOAD,
	input  wire logic [7:0] TX_DATA,
	input  wire logic       RX_READ,
	// Status.
	output logic            SOFT_RESET_HOLD,
	output logic            TRANSMIT_DIRECTION,
	output logic            BUS_BUSY_FLAG,
	output logic            START_MATCH_FLAG,
	output logic            TRANSMIT_IRQ_ENABLE,
	output logic            RECEIVE_IRQ_ENABLE,
	output logic            TRANSMIT_IRQ_FLAG,
	output logic            RECEIVE_IRQ_FLAG,
	output logic [7:0]      RX_DATA,
	output logic            WAKE_REQUEST,
	// Bus pins.
	input  wire logic       SDA_IN,
	output logic            SDA_OUT,
	output logic            SDA_OE,
	input  wire logic       SCL_IN,
	output logic            SCL_OUT,
	output logic            SCL_OE
);

	// System domain state.
	logic        hold_r;
	logic        en_r;
	logic        dir_r;
	logic        busy_r;
	logic        match_flag_r;
	logic        txie_r;
	logic        rxie_r;
	logic        txifg_r;
	logic        rxifg_r;
	logic        tx_full_r;
	logic [7:0]  tx_buf_r;
	logic [7:0]  rx_data_r;
	logic        wake_r;
	// Events and levels arriving from the link domain.
	logic        start_p;
	logic        match_p;
	logic        rx_p;
	logic        taken_p;
	logic        busy_s;
	// Link domain state.
	logic        en_l;
	logic        tx_full_l;
	logic        sda_s;
	logic        scl_s;
	logic        sda_q;
	logic        scl_q;
	link_state_t state_r;
	logic [3:0]  cnt_r;
	logic [7:0]  sh_r;
	logic [7:0]  tx_sh_r;
	logic        sda_oe_r;
	logic        zero_r;
	logic        busy_l_r;
	logic        ten_seen_r;
	logic        nack_r;
	logic        match_dir_r;
	logic [7:0]  rx_byte_r;
	logic        start_ev_r;
	logic        match_ev_r;
	logic        rx_ev_r;
	logic        taken_ev_r;
	// Link domain decodes.
	logic        start_det;
	logic        stop_det;
	logic        scl_rise;
	logic        scl_fall;
	logic        gc_hit;
	logic        hi_hit;
	logic        lo7_hit;
	logic [7:0]  tx_next;

	// ---------------- System domain ----------------

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			hold_r <= HOLD_RESET_VAL; // RULE1
		else if (SOFT_RESET_SET)
			hold_r <= 1'b1; // RULE1
		else if (SOFT_RESET_CLEAR)
			hold_r <= 1'b0; // RULE3
	end

	// Slave engine runs only in two-wire slave mode with soft reset released.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			en_r <= 1'b0;
		else
			en_r <= (SERIAL_MODE_SELECT == MODE_TWO_WIRE) && SYNCHRONOUS_MODE_SELECT &&
				!MASTER_SELECT && !hold_r && !SOFT_RESET_SET; // RULE2 RULE16 RULE3
	end

	// Direction is not touched by soft reset; a match overrides a software write.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			dir_r <= DIR_RESET_VAL; // RULE17
		else if (match_p)
			dir_r <= match_dir_r; // RULE23 RULE24
		else if (DIRECTION_WRITE)
			dir_r <= DIRECTION_VALUE; // RULE17
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			busy_r       <= 1'b0;
			match_flag_r <= 1'b0;
		end else if (hold_r) begin
			busy_r       <= 1'b0; // RULE5
			match_flag_r <= 1'b0; // RULE5
		end else begin
			busy_r <= busy_s; // RULE12
			if (match_p)
				match_flag_r <= 1'b1; // RULE20
			else if (START_MATCH_CLEAR)
				match_flag_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			txie_r <= 1'b0;
			rxie_r <= 1'b0;
		end else if (hold_r) begin
			txie_r <= 1'b0; // RULE6
			rxie_r <= 1'b0; // RULE6
		end else if (IRQ_ENABLE_WRITE) begin
			txie_r <= IRQ_ENABLE_VALUE[1];
			rxie_r <= IRQ_ENABLE_VALUE[0];
		end
	end

	// Transmit path: the flag asks for data, a load fills the buffer,
	// and the link taking the byte asks again.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			txifg_r   <= 1'b0;
			tx_full_r <= 1'b0;
		end else if (hold_r) begin
			txifg_r   <= 1'b0; // RULE6
			tx_full_r <= 1'b0;
		end else begin
			if ((match_p && match_dir_r) || taken_p)
				txifg_r <= 1'b1;
			else if (TX_LOAD)
				txifg_r <= 1'b0;
			if (TX_LOAD)
				tx_full_r <= 1'b1;
			else if (taken_p)
				tx_full_r <= 1'b0;
		end
	end

	// The buffer is read by the link without a handshake on the word itself.
	// Software should load only while the transmit flag is set, never while
	// a byte is being taken.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			tx_buf_r <= 8'h00;
		else if (TX_LOAD)
			tx_buf_r <= TX_DATA;
	end

	// The link holds its received byte for a whole byte time, so it is
	// stable when the event pulse arrives here.
	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			rxifg_r   <= 1'b0;
			rx_data_r <= 8'h00;
		end else if (hold_r) begin
			rxifg_r <= 1'b0; // RULE6
		end else if (rx_p) begin
			rxifg_r   <= 1'b1;
			rx_data_r <= rx_byte_r;
		end else if (RX_READ) begin
			rxifg_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			wake_r <= 1'b0;
		else
			wake_r <= start_p && en_r && !dir_r; // RULE22
	end

	assign SOFT_RESET_HOLD     = hold_r;
	assign TRANSMIT_DIRECTION  = dir_r;
	assign BUS_BUSY_FLAG       = busy_r;
	assign START_MATCH_FLAG    = match_flag_r;
	assign TRANSMIT_IRQ_ENABLE = txie_r;
	assign RECEIVE_IRQ_ENABLE  = rxie_r;
	assign TRANSMIT_IRQ_FLAG   = txifg_r;
	assign RECEIVE_IRQ_FLAG    = rxifg_r;
	assign RX_DATA             = rx_data_r;
	assign WAKE_REQUEST        = wake_r;

	// ---------------- Domain crossings ----------------

	bit_sync #(.RESET_VAL(1'b0)) en_sync (.clk(LINK_CLK), .rst_n(RESETN), .d(en_r), .q(en_l));
	bit_sync #(.RESET_VAL(1'b0)) txf_sync (.clk(LINK_CLK), .rst_n(RESETN), .d(tx_full_r),
		.q(tx_full_l));
	bit_sync #(.RESET_VAL(1'b0)) busy_sync (.clk(SYS_CLK), .rst_n(RESETN), .d(busy_l_r),
		.q(busy_s));
	// Pins pass two flip-flops; a fast-mode bit still spans dozens of samples.
	bit_sync #(.RESET_VAL(LINE_RESET_VAL)) sda_sync (.clk(LINK_CLK), .rst_n(RESETN),
		.d(SDA_IN), .q(sda_s)); // RULE21
	bit_sync #(.RESET_VAL(LINE_RESET_VAL)) scl_sync (.clk(LINK_CLK), .rst_n(RESETN),
		.d(SCL_IN), .q(scl_s)); // RULE21

	pulse_cross start_x (.src_clk(LINK_CLK), .dst_clk(SYS_CLK), .rst_n(RESETN),
		.src_pulse(start_ev_r), .dst_pulse(start_p));
	pulse_cross match_x (.src_clk(LINK_CLK), .dst_clk(SYS_CLK), .rst_n(RESETN),
		.src_pulse(match_ev_r), .dst_pulse(match_p));
	pulse_cross rx_x (.src_clk(LINK_CLK), .dst_clk(SYS_CLK), .rst_n(RESETN),
		.src_pulse(rx_ev_r), .dst_pulse(rx_p));
	pulse_cross taken_x (.src_clk(LINK_CLK), .dst_clk(SYS_CLK), .rst_n(RESETN),
		.src_pulse(taken_ev_r), .dst_pulse(taken_p));

	// ---------------- Link domain ----------------

	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sda_q <= LINE_RESET_VAL;
			scl_q <= LINE_RESET_VAL;
		end else begin
			sda_q <= sda_s;
			scl_q <= scl_s;
		end
	end

	assign start_det = scl_s && scl_q && sda_q && !sda_s; // RULE11
	assign stop_det  = scl_s && scl_q && !sda_q && sda_s; // RULE11
	assign scl_rise  = scl_s && !scl_q;
	assign scl_fall  = !scl_s && scl_q;
	// Own address is read across domains unsynchronised; it must only change
	// while soft reset holds the engine idle.
	assign gc_hit  = GENERAL_CALL_RESPOND && sh_r == {GENERAL_CALL_ADDR, 1'b0}; // RULE19
	assign hi_hit  = sh_r[7:1] == {TEN_BIT_PREFIX, OWN_ADDRESS_REG[9:8]}; // RULE14 RULE18
	assign lo7_hit = sh_r[7:1] == OWN_ADDRESS_REG[6:0]; // RULE9 RULE18
	assign tx_next = tx_full_l ? tx_buf_r : IDLE_BYTE;

	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN)
			busy_l_r <= 1'b0;
		else if (!en_l)
			busy_l_r <= 1'b0;
		else if (start_det)
			busy_l_r <= 1'b1; // RULE12
		else if (stop_det)
			busy_l_r <= 1'b0; // RULE12
	end

	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN)
			start_ev_r <= 1'b0;
		else
			start_ev_r <= start_det && en_l; // RULE22
	end

	// Open-drain: the data value is always low; only the SDA enable moves, the SCL enable stays low.
	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN)
			zero_r <= 1'b0;
		else
			zero_r <= 1'b0; // RULE25
	end
	assign SDA_OUT = zero_r;
	assign SCL_OUT = zero_r;
	assign SCL_OE  = zero_r;
	assign SDA_OE  = sda_oe_r;

	always_ff @(posedge LINK_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_r     <= L_IDLE;
			cnt_r       <= 4'h0;
			sh_r        <= 8'h00;
			tx_sh_r     <= 8'h00;
			sda_oe_r    <= 1'b0;
			ten_seen_r  <= 1'b0;
			nack_r      <= 1'b0;
			match_dir_r <= 1'b0;
			rx_byte_r   <= 8'h00;
			match_ev_r  <= 1'b0;
			rx_ev_r     <= 1'b0;
			taken_ev_r  <= 1'b0;
		end else begin
			match_ev_r <= 1'b0;
			rx_ev_r    <= 1'b0;
			taken_ev_r <= 1'b0;
			if (!en_l) begin
				state_r    <= L_IDLE; // RULE3
				sda_oe_r   <= 1'b0; // RULE4
				ten_seen_r <= 1'b0;
				cnt_r      <= 4'h0;
			end else if (start_det) begin
				// A repeated START keeps the ten-bit history for the read header.
				state_r  <= L_ADDR; // RULE15
				cnt_r    <= 4'h0;
				sda_oe_r <= 1'b0;
			end else if (stop_det) begin
				state_r    <= L_IDLE;
				ten_seen_r <= 1'b0;
				sda_oe_r   <= 1'b0;
			end else if (state_r != L_IDLE && scl_rise) begin
				if (cnt_r < ACK_CLOCK)
					sh_r <= {sh_r[6:0], sda_s}; // RULE8
				else
					nack_r <= sda_s;
				if (cnt_r != ACK_DONE)
					cnt_r <= cnt_r + 4'h1;
			end else if (state_r != L_IDLE && scl_fall) begin
				if (cnt_r == ACK_CLOCK) begin
					unique case (state_r)
						L_IDLE: begin
						end
						L_ADDR: begin
							if (gc_hit) begin
								sda_oe_r    <= 1'b1; // RULE10
								match_dir_r <= 1'b0;
								match_ev_r  <= 1'b1;
								state_r     <= L_RX;
							end else if (OWN_ADDRESS_TEN_BIT) begin
								if (hi_hit && !sh_r[0]) begin
									sda_oe_r <= 1'b1; // RULE14
									state_r  <= L_ADDR2;
								end else if (hi_hit && ten_seen_r) begin
									sda_oe_r    <= 1'b1; // RULE15
									match_dir_r <= 1'b1; // RULE23
									match_ev_r  <= 1'b1;
									state_r     <= L_TX;
								end else begin
									state_r <= L_IDLE;
								end
							end else if (lo7_hit) begin
								sda_oe_r    <= 1'b1; // RULE10
								match_dir_r <= sh_r[0]; // RULE23 RULE24
								match_ev_r  <= 1'b1; // RULE20
								state_r     <= sh_r[0] ? L_TX : L_RX;
							end else begin
								state_r <= L_IDLE;
							end
						end
						L_ADDR2: begin
							if (sh_r == OWN_ADDRESS_REG[7:0]) begin
								sda_oe_r    <= 1'b1; // RULE14
								match_dir_r <= 1'b0; // RULE24
								match_ev_r  <= 1'b1; // RULE20
								ten_seen_r  <= 1'b1;
								state_r     <= L_RX;
							end else begin
								state_r <= L_IDLE;
							end
						end
						L_RX: begin
							rx_byte_r <= sh_r;
							rx_ev_r   <= 1'b1;
							sda_oe_r  <= 1'b1; // RULE10
						end
						L_TX: begin
							sda_oe_r <= 1'b0; // RULE10
						end
					endcase
				end else if (cnt_r == ACK_DONE) begin
					sda_oe_r <= 1'b0;
					cnt_r    <= 4'h0;
					// In transmit, the acknowledge just sampled is our own
					// address acknowledge or the master's answer to our byte.
					if (state_r == L_TX) begin
						if (nack_r) begin
							state_r <= L_IDLE;
						end else begin
							sda_oe_r   <= !tx_next[7]; // RULE8 RULE13
							tx_sh_r    <= {tx_next[6:0], 1'b0};
							taken_ev_r <= tx_full_l;
						end
					end
				end else if (state_r == L_TX) begin
					sda_oe_r <= !tx_sh_r[7]; // RULE13
					tx_sh_r  <= {tx_sh_r[6:0], 1'b0};
				end
			end
		end
	end

	// ---------------- Checks ----------------

	hold_stays_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RULE1
		hold_r && !SOFT_RESET_CLEAR |=> hold_r)
		else $error("soft reset hold dropped without a clear");

	mode_gate_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RULE16
		en_r |-> $past(SERIAL_MODE_SELECT) == MODE_TWO_WIRE && $past(SYNCHRONOUS_MODE_SELECT)
			&& !$past(MASTER_SELECT) && !$past(hold_r))
		else $error("engine enabled outside two-wire slave mode");

	hold_clears_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RULE6
		$rose(hold_r) |=> !txie_r && !rxie_r && !txifg_r && !rxifg_r && !match_flag_r && !busy_r)
		else $error("soft reset left an enable or flag set");

	match_dir_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RULE23
		match_p |=> dir_r == match_dir_r && (hold_r || match_flag_r))
		else $error("address match did not update direction and flag");

	wake_start_a: assert property (@(posedge SYS_CLK) disable iff (!RESETN) // RULE22
		start_p && en_r && !dir_r |=> wake_r)
		else $error("start in slave receiver gave no wake request");

	release_bus_a: assert property (@(posedge LINK_CLK) disable iff (!RESETN) // RULE4
		!en_l |=> !sda_oe_r[*2])
		else $error("SDA pulled while engine disabled");

	busy_track_a: assert property (@(posedge LINK_CLK) disable iff (!RESETN) // RULE12
		en_l && (start_det || (busy_l_r && !stop_det)) |=> busy_l_r)
		else $error("bus busy not held from START to STOP");

	ack_drive_a: assert property (@(posedge LINK_CLK) disable iff (!RESETN) // RULE10
		en_l && !start_det && !stop_det && state_r == L_RX && scl_fall && cnt_r == ACK_CLOCK
			|=> sda_oe_r && rx_ev_r)
		else $error("received byte not acknowledged");

	sda_hold_a: assert property (@(posedge LINK_CLK) disable iff (!RESETN) // RULE13
		en_l && scl_s && scl_q && !start_det && !stop_det |=> $stable(sda_oe_r))
		else $error("SDA moved while SCL was high");

endmodule

// file: logic/two_wire_pkg.sv
// Shared constants and types for the two-wire slave engine.
// Assumes a 200 MHz system clock and a separate link sampling clock.
package two_wire_pkg;

	// Serial mode select code that picks the two-wire bus.
	localparam logic [1:0] MODE_TWO_WIRE     = 2'h3;
	// First-byte prefix of a ten-bit address.
	localparam logic [4:0] TEN_BIT_PREFIX    = 5'h1e;
	localparam logic [6:0] GENERAL_CALL_ADDR = 7'h00;
	// Rising SCL edges counted per byte: eight data clocks, then the acknowledge clock.
	localparam logic [3:0] ACK_CLOCK         = 4'h8;
	localparam logic [3:0] ACK_DONE          = 4'h9;
	// Byte sent when software has nothing loaded; all ones leaves SDA released.
	localparam logic [7:0] IDLE_BYTE         = 8'hff;
	// Values after reset.
	localparam logic       HOLD_RESET_VAL    = 1'b1;
	localparam logic       DIR_RESET_VAL     = 1'b0;
	localparam logic       LINE_RESET_VAL    = 1'b1;

	// Bus rates and clock periods.
	localparam int STD_RATE_KBPS  = 100;
	localparam int FAST_RATE_KBPS = 400;
	localparam int SYS_CLK_NS     = 5;
	localparam int LINK_CLK_NS    = 48;
	// Link samples taken in one fast-mode bit, rounded down.
	localparam int FAST_BIT_NS    = 1000000 / FAST_RATE_KBPS;
	localparam int SAMPLES_PER_BIT = FAST_BIT_NS / LINK_CLK_NS;

	typedef enum logic [2:0] {
		L_IDLE  = 3'b000,
		L_ADDR  = 3'b001,
		L_ADDR2 = 3'b010,
		L_RX    = 3'b011,
		L_TX    = 3'b100
	} link_state_t;

endpackage

// file: logic/bit_sync.sv
// Two flip-flop synchroniser for one level.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/10ps
module bit_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Level in and out.
	input  wire logic d,
	output logic      q
);
	logic meta_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= RESET_VAL;
			q      <= RESET_VAL;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// file: logic/pulse_cross.sv
// Carries one-cycle event pulses from one clock domain to another.
// Assumes pulses are spaced by several destination clocks.
`timescale 1ns/10ps
module pulse_cross (
	// Clocks and reset.
	input  wire logic src_clk,
	input  wire logic dst_clk,
	input  wire logic rst_n,
	// Event in and out.
	input  wire logic src_pulse,
	output logic      dst_pulse
);
	logic tog_r;
	logic meta_r;
	logic sync_r;
	logic last_r;

	always_ff @(posedge src_clk or negedge rst_n) begin
		if (!rst_n)
			tog_r <= 1'b0;
		else if (src_pulse)
			tog_r <= ~tog_r;
	end

	always_ff @(posedge dst_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r    <= 1'b0;
			sync_r    <= 1'b0;
			last_r    <= 1'b0;
			dst_pulse <= 1'b0;
		end else begin
			meta_r    <= tog_r;
			sync_r    <= meta_r;
			last_r    <= sync_r;
			dst_pulse <= sync_r ^ last_r;
		end
	end
endmodule

// file: verification/bus_master_model.sv
// Behavioural two-wire bus master that clocks bytes to and from the slave.
// Assumes the bench forms both wires from the pull-downs with pull-ups.
`timescale 1ns/10ps
module bus_master_model #(
	parameter int HALF = 500
) (
	// Wire level on SDA.
	input  wire logic sda_line,
	// Pull-down enables for the two wires.
	output logic      scl_pull,
	output logic      sda_pull
);
	initial {scl_pull, sda_pull} = 2'b00;
	// SDA moves only mid-way through SCL low, so no false START or STOP appears.
	task automatic clock_bit(input logic b, output logic r);
		#(HALF/2) sda_pull = !b;
		#(HALF/2) scl_pull = 1'b0;
		#(HALF/2) r = sda_line;
		#(HALF/2) scl_pull = 1'b1;
	endtask
	// Serves as a first or a repeated START.
	task automatic start_cond();
		#(HALF/2) sda_pull = 1'b0;
		#(HALF/2) scl_pull = 1'b0;
		#HALF sda_pull = 1'b1;
		#HALF scl_pull = 1'b1;
	endtask
	task automatic stop_cond();
		#(HALF/2) sda_pull = 1'b1;
		#(HALF/2) scl_pull = 1'b0;
		#HALF sda_pull = 1'b0;
		#HALF;
	endtask
	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], r);
		end
		clock_bit(1'b1, r);
		ack = !r;
	endtask
	task automatic read_byte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, d[i]);
		end
		clock_bit(!ack, r);
	endtask
endmodule

// file: verification/two_wire_bus_engine_slave_core_bench.sv
// Self-checking bench for the two-wire slave engine against a behavioural master.
// Assumes bus_master_model and open-drain wires with pull-ups made here.
`timescale 1ns/10ps
module two_wire_bus_engine_slave_core_bench
	import two_wire_pkg::*;
;
	localparam int LIMIT = 80000;
	logic       sys_clk, resetn, link_clk, sync_sel, mst_sel, ten_bit, gc_resp, dir_val;
	logic       hold, tx_dir, busy, match, tie, rie, tif, rif, wake, ack;
	logic       sda_out, sda_oe, scl_out, scl_oe, m_scl, m_sda;
	logic [1:0] mode_sel, ie_val;
	logic [9:0] own_addr;
	logic [6:0] stb;
	logic [7:0] tx_data, rx_data, d, wakes;
	int         miscompares, samples_checked, cycles;
	wire        sda = !(sda_oe | m_sda);
	wire        scl = !(scl_oe | m_scl);

	two_wire_bus_engine_slave_core u_dut (
		.SYS_CLK(sys_clk), .RESETN(resetn), .LINK_CLK(link_clk),
		.SERIAL_MODE_SELECT(mode_sel), .SYNCHRONOUS_MODE_SELECT(sync_sel),
		.MASTER_SELECT(mst_sel), .OWN_ADDRESS_REG(own_addr), .OWN_ADDRESS_TEN_BIT(ten_bit),
		.GENERAL_CALL_RESPOND(gc_resp), .SOFT_RESET_SET(stb[0]), .SOFT_RESET_CLEAR(stb[1]),
		.DIRECTION_WRITE(stb[2]), .DIRECTION_VALUE(dir_val), .IRQ_ENABLE_WRITE(stb[3]),
		.IRQ_ENABLE_VALUE(ie_val), .START_MATCH_CLEAR(stb[4]), .TX_LOAD(stb[5]),
		.TX_DATA(tx_data), .RX_READ(stb[6]), .SOFT_RESET_HOLD(hold),
		.TRANSMIT_DIRECTION(tx_dir), .BUS_BUSY_FLAG(busy), .START_MATCH_FLAG(match),
		.TRANSMIT_IRQ_ENABLE(tie), .RECEIVE_IRQ_ENABLE(rie), .TRANSMIT_IRQ_FLAG(tif),
		.RECEIVE_IRQ_FLAG(rif), .RX_DATA(rx_data), .WAKE_REQUEST(wake),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl),
		.SCL_OUT(scl_out), .SCL_OE(scl_oe)
	);
	bus_master_model u_master (.sda_line(sda), .scl_pull(m_scl), .sda_pull(m_sda));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#7;
		forever #24 link_clk = ~link_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (wake === 1'b1) wakes++;
		if (cycles == LIMIT) begin
			miscompares++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask
	// Strobes: 0 hold set, 1 hold clear, 2 direction, 3 enables, 4 match clear,
	// 5 transmit load, 6 receive read.
	task automatic pulse(input int k);
		@(negedge sys_clk);
		stb[k] = 1'b1;
		@(negedge sys_clk);
		stb[k] = 1'b0;
	endtask
	// Flags lag the wires by the synchroniser and the crossing.
	task automatic settle();
		repeat (60) @(negedge sys_clk);
	endtask
	task automatic configure(input logic [1:0] m, input logic s, x, t, g, input logic [9:0] a);
		pulse(0);
		{mode_sel, sync_sel, mst_sel, ten_bit, gc_resp, own_addr} = {m, s, x, t, g, a};
		pulse(1);
		settle();
	endtask
	task automatic probe(input logic [7:0] b, input logic e);
		u_master.start_cond();
		u_master.write_byte(b, ack);
		check(ack, e);
		u_master.stop_cond();
	endtask
	// There is no clock stretching, so the byte must be loaded during the ack clock.
	task automatic addr_read(input logic [7:0] b, t);
		fork
			u_master.write_byte(b, ack);
			begin
				for (int i = 0; i < 4000 && tif !== 1'b1; i++) @(negedge sys_clk);
				tx_data = t;
				pulse(5);
			end
		join
		settle();
		check({ack, match, tx_dir, tif}, 4'hf);
		u_master.read_byte(1'b0, d);
		check(d, t);
	endtask

	task automatic t_held();
		check({hold, busy, sda_oe, scl_oe}, 4'h8);
		ie_val = 2'h3;
		pulse(3);
		check({tie, rie}, 2'h0);
		probe(8'h54, 1'b0);
		check(busy, 1'b0);
	endtask
	task automatic t_write();
		configure(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 10'h02a);
		check(hold, 1'b0);
		dir_val = 1'b1;
		pulse(2);
		check(tx_dir, 1'b1);
		dir_val = 1'b0;
		pulse(2);
		pulse(3);
		check({tx_dir, tie, rie}, 3'h3);
		wakes = 8'h00;
		u_master.start_cond();
		settle();
		check({busy, wakes}, 9'h101);
		u_master.write_byte(8'h54, ack);
		settle();
		check({ack, match, tx_dir}, 3'h6);
		u_master.write_byte(8'ha5, ack);
		settle();
		check({ack, rif, rx_data}, 10'h3a5);
		pulse(6);
		check(rif, 1'b0);
		u_master.write_byte(8'h0f, ack);
		settle();
		check({ack, rif, rx_data}, 10'h30f);
		check({sda_out, scl_out, scl_oe}, 3'h0);
		u_master.stop_cond();
		settle();
		check(busy, 1'b0);
	endtask
	// Hold is set while the slave is pulling SDA for the address ack.
	task automatic t_abort();
		u_master.start_cond();
		fork
			u_master.write_byte(8'h54, ack);
			begin
				for (int i = 0; i < 4000 && sda_oe !== 1'b1; i++) @(negedge sys_clk);
				pulse(0);
			end
		join
		check({ack, sda_oe, scl_oe, hold}, 4'h1);
		check({busy, match, tie, rie, tif, rif}, 6'h00);
		check(rx_data, 8'h0f);
		u_master.stop_cond();
	endtask
	task automatic t_refuse();
		configure(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 10'h02a);
		probe(8'h26, 1'b0);
		settle();
		check(match, 1'b0);
		probe(8'h00, 1'b0);
		configure(2'h3, 1'b1, 1'b0, 1'b0, 1'b1, 10'h02a);
		probe(8'h00, 1'b1);
		for (int m = 0; m < 3; m++) begin
			configure(m[1:0], 1'b1, 1'b0, 1'b0, 1'b0, 10'h02a);
			probe(8'h54, 1'b0);
		end
		configure(2'h3, 1'b1, 1'b1, 1'b0, 1'b0, 10'h02a);
		probe(8'h54, 1'b0);
		configure(2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 10'h02a);
		probe(8'h54, 1'b0);
	endtask
	task automatic t_read();
		configure(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 10'h02a);
		u_master.start_cond();
		addr_read(8'h55, 8'h3c);
		u_master.stop_cond();
	endtask
	task automatic t_ten();
		configure(2'h3, 1'b1, 1'b0, 1'b1, 1'b0, 10'h2b5);
		probe(8'h6a, 1'b0);
		u_master.start_cond();
		u_master.write_byte(8'hf4, ack);
		check(ack, 1'b1);
		u_master.write_byte(8'hb5, ack);
		settle();
		check({ack, match, tx_dir}, 3'h6);
		pulse(4);
		check(match, 1'b0);
		u_master.start_cond();
		addr_read(8'hf5, 8'h81);
		u_master.stop_cond();
	endtask

	initial begin
		{resetn, stb, dir_val, ie_val, tx_data, wakes} = '0;
		{mode_sel, sync_sel, mst_sel, ten_bit, gc_resp} = {MODE_TWO_WIRE, 4'h8};
		own_addr = 10'h02a;
		miscompares = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (20) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		t_held();
		t_write();
		t_abort();
		t_refuse();
		t_read();
		t_ten();
		print_verdict();
	end
endmodule
